// ===== rtl/timer16_pkg.sv
package timer16_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL_A    = 8'h80;
	localparam logic [7:0]  ADDR_CTRL_B    = 8'h81;
	localparam logic [7:0]  ADDR_CMP_A_LO  = 8'h88;
	localparam logic [7:0]  ADDR_CMP_A_HI  = 8'h89;
	localparam logic [7:0]  ADDR_CMP_B_LO  = 8'h8a;
	localparam logic [7:0]  ADDR_CMP_B_HI  = 8'h8b;
	localparam logic [7:0]  ADDR_CAPT_LO   = 8'h86;
	localparam logic [7:0]  ADDR_CAPT_HI   = 8'h87;
	localparam logic [7:0]  ADDR_COUNT_LO  = 8'h84;
	localparam logic [7:0]  ADDR_COUNT_HI  = 8'h85;
	localparam logic [7:0]  ADDR_STATUS    = 8'h96;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          CA_OM_A_LSB    = 6;
	localparam int          CA_OM_B_LSB    = 4;
	localparam int          CA_WM_LSB      = 0;
	localparam int          CB_WM_LSB      = 3;
	localparam int          CB_SEL_LSB     = 0;
	localparam logic [7:0]  CTRL_A_WMASK   = 8'hf3;
	localparam logic [7:0]  CTRL_B_WMASK   = 8'h1f;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam int          ST_OVF_BIT     = 0;
	localparam int          ST_CMA_BIT     = 1;
	localparam int          ST_CMB_BIT     = 2;

	// ----------------------------------------------------------------
	// Counter limits and prescaler
	// ----------------------------------------------------------------
	localparam logic [15:0] CNT_BOTTOM     = 16'h0000;
	localparam logic [15:0] CNT_MAX        = 16'hffff;
	localparam logic [15:0] TOP_8BIT       = 16'h00ff;
	localparam logic [15:0] TOP_9BIT       = 16'h01ff;
	localparam logic [15:0] TOP_10BIT      = 16'h03ff;
	localparam int          PRESCALE_W     = 10;
	localparam logic [9:0]  DIV8_MASK      = 10'h007;
	localparam logic [9:0]  DIV64_MASK     = 10'h03f;
	localparam logic [9:0]  DIV256_MASK    = 10'h0ff;
	localparam logic [9:0]  DIV1024_MASK   = 10'h3ff;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_STOP    = 3'b000,
		SEL_DIV1    = 3'b001,
		SEL_DIV8    = 3'b010,
		SEL_DIV64   = 3'b011,
		SEL_DIV256  = 3'b100,
		SEL_DIV1024 = 3'b101,
		SEL_EXT_FALL = 3'b110,
		SEL_EXT_RISE = 3'b111
	} tick_sel_e;

	typedef enum logic [1:0] {
		OM_OFF    = 2'b00,
		OM_TOGGLE = 2'b01,
		OM_CLEAR  = 2'b10,
		OM_SET    = 2'b11
	} out_mode_e;

	typedef enum logic [1:0] {
		KIND_NONPWM = 2'b00,
		KIND_FAST   = 2'b01,
		KIND_PHASE  = 2'b10,
		KIND_PFC    = 2'b11
	} mode_kind_e;

	localparam logic [3:0]  WM_NORMAL      = 4'h0;
	localparam logic [3:0]  WM_PC_8BIT     = 4'h1;
	localparam logic [3:0]  WM_PC_9BIT     = 4'h2;
	localparam logic [3:0]  WM_PC_10BIT    = 4'h3;
	localparam logic [3:0]  WM_FAST_8BIT   = 4'h5;
	localparam logic [3:0]  WM_FAST_9BIT   = 4'h6;
	localparam logic [3:0]  WM_FAST_10BIT  = 4'h7;
	localparam logic [3:0]  WM_CTC_CMP     = 4'h4;
	localparam logic [3:0]  WM_CTC_CAPT    = 4'hc;
	localparam logic [3:0]  WM_PFC_CAPT    = 4'h8;
	localparam logic [3:0]  WM_PFC_CMP     = 4'h9;
	localparam logic [3:0]  WM_PC_CAPT     = 4'ha;
	localparam logic [3:0]  WM_PC_CMP      = 4'hb;
	localparam logic [3:0]  WM_FAST_CAPT   = 4'he;
	localparam logic [3:0]  WM_FAST_CMP    = 4'hf;

endpackage : timer16_pkg

// ===== rtl/timer16_waveform_mode_control.sv
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Synchronous counter; tick is one-cycle enable.
// RULE_02: Frequency-correct modes load compares at BOTTOM.
// RULE_03: Nonzero output mode overrides pin per channel.
// RULE_04: Pin driven only when direction selects output.
// RULE_05: Output mode meaning depends on mode kind.
// RULE_06: Non-PWM: off, toggle, clear, set on match.
// RULE_07: Fast PWM: 10 non-inverting, 11 inverting.
// RULE_08: Fast PWM toggle A only modes 14/15.
// RULE_09: Fast PWM compare equal TOP: only BOTTOM action.
// RULE_10: Dual-slope 10: clear up, set down.
// RULE_11: Dual-slope 11: set up, clear down.
// RULE_12: Dual-slope toggle A only modes 9/11.
// RULE_13: Mode low bits in control A 1:0.
// RULE_14: Normal/CLEAR_ON_MATCH_MODE tops, immediate update, flag at MAX.
// RULE_15: Phase correct tops, update TOP, flag BOTTOM.
// RULE_16: Modes 8/9 update and flag at BOTTOM.
// RULE_17: Fast PWM tops, update BOTTOM, flag TOP.
// RULE_18: Software never programs reserved mode 13.
// RULE_19: Control A bits 3:2 read zero.
// RULE_20: Mode high bits in control B 4:3.
// RULE_21: Tick select: stop, prescales, external edges.
// RULE_22: Dual-slope counts BOTTOM to TOP and back.
module timer16_waveform_mode_control
	import timer16_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_write_i,
	input  wire logic       reg_read_i,
	output logic      [7:0] reg_rdata_o,
	// Pins
	input  wire logic       ext_count_i,
	input  wire logic       capture_evt_i,
	input  wire logic       dir_out_a_i,
	input  wire logic       dir_out_b_i,
	output logic            compare_out_a_o,
	output logic            compare_out_b_o,
	output logic            pin_override_a_o,
	output logic            pin_override_b_o,
	output logic            pin_drive_en_a_o,
	output logic            pin_drive_en_b_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]            ctrl_a;
		logic [7:0]            ctrl_b;
		logic [15:0]           count;
		logic                  down;
		logic [15:0]           cmp_a;
		logic [15:0]           cmp_b;
		logic [15:0]           buf_a;
		logic [15:0]           buf_b;
		logic [15:0]           capt;
		logic [7:0]            temp;
		logic                  out_a;
		logic                  out_b;
		logic [2:0]            flags;
		logic [PRESCALE_W-1:0] pre;
		logic [2:0]            ext_sync;
		logic [7:0]            rdata;
	} state_s;

	state_s q, d;

	logic [3:0]  wm;
	mode_kind_e  kind;
	logic [15:0] top;
	logic        tick, at_top, at_bottom, match_a, match_b, ignore_a, ignore_b;
	logic        upd_now, tov_set;
	out_mode_e   om_a, om_b;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	always_comb
	begin
		wm = {q.ctrl_b[CB_WM_LSB +: 2], q.ctrl_a[CA_WM_LSB +: 2]}; // RULE_13 RULE_20
		om_a = out_mode_e'(q.ctrl_a[CA_OM_A_LSB +: 2]);
		om_b = out_mode_e'(q.ctrl_a[CA_OM_B_LSB +: 2]);
		case (wm)
			WM_PC_8BIT, WM_PC_9BIT, WM_PC_10BIT, WM_PC_CAPT, WM_PC_CMP:
				kind = KIND_PHASE; // RULE_15
			WM_PFC_CAPT, WM_PFC_CMP:                  kind = KIND_PFC;   // RULE_16
			WM_FAST_8BIT, WM_FAST_9BIT, WM_FAST_10BIT, WM_FAST_CAPT, WM_FAST_CMP:
				kind = KIND_FAST; // RULE_17
			default:                                   kind = KIND_NONPWM;
		endcase
		// Reserved mode 13 falls to normal counting
		case (wm)
			WM_PC_8BIT, WM_FAST_8BIT:                     top = TOP_8BIT;
			WM_PC_9BIT, WM_FAST_9BIT:                     top = TOP_9BIT;
			WM_PC_10BIT, WM_FAST_10BIT:                   top = TOP_10BIT;
			WM_CTC_CMP, WM_PFC_CMP, WM_PC_CMP, WM_FAST_CMP: top = q.cmp_a; // RULE_14
			WM_CTC_CAPT, WM_PFC_CAPT, WM_PC_CAPT, WM_FAST_CAPT: top = q.capt;
			default:                                      top = CNT_MAX;
		endcase
	end

	// ----------------------------------------------------------------
	// Tick select
	// ----------------------------------------------------------------
	always_comb
	begin
		case (tick_sel_e'(q.ctrl_b[CB_SEL_LSB +: 3])) // RULE_21
			SEL_DIV1:     tick = 1'b1;
			SEL_DIV8:     tick = (q.pre & DIV8_MASK) == DIV8_MASK;
			SEL_DIV64:    tick = (q.pre & DIV64_MASK) == DIV64_MASK;
			SEL_DIV256:   tick = (q.pre & DIV256_MASK) == DIV256_MASK;
			SEL_DIV1024:  tick = q.pre == DIV1024_MASK;
			SEL_EXT_FALL: tick = q.ext_sync[2] & ~q.ext_sync[1];
			SEL_EXT_RISE: tick = ~q.ext_sync[2] & q.ext_sync[1];
			default:      tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.pre = q.pre + 1'b1;
		d.ext_sync = {q.ext_sync[1:0], ext_count_i};
		at_top = q.count == top;
		at_bottom = q.count == CNT_BOTTOM;
		match_a = q.count == q.cmp_a;
		match_b = q.count == q.cmp_b;
		ignore_a = (kind == KIND_FAST) && (q.cmp_a == top) && om_a[1]; // RULE_09
		ignore_b = (kind == KIND_FAST) && (q.cmp_b == top) && om_b[1]; // RULE_09
		upd_now = 1'b0;
		tov_set = 1'b0;

		// Capture is off while the capture register sets TOP
		if (capture_evt_i && !(wm inside {WM_CTC_CAPT, WM_PFC_CAPT, WM_PC_CAPT, WM_FAST_CAPT}))
		begin
			d.capt = q.count;
		end

		// Counter and waveform run only on a tick
		if (tick) // RULE_01
		begin
			case (kind)
				KIND_NONPWM:
				begin
					d.count = (at_top && wm != WM_NORMAL) ? CNT_BOTTOM : q.count + 1'b1;
					tov_set = q.count == CNT_MAX; // RULE_14
					if (match_a)
					begin
						case (om_a) // RULE_06
							OM_TOGGLE: d.out_a = ~q.out_a;
							OM_CLEAR:  d.out_a = 1'b0;
							OM_SET:    d.out_a = 1'b1;
							default:   d.out_a = q.out_a;
						endcase
					end
					if (match_b)
					begin
						case (om_b) // RULE_06
							OM_TOGGLE: d.out_b = ~q.out_b;
							OM_CLEAR:  d.out_b = 1'b0;
							OM_SET:    d.out_b = 1'b1;
							default:   d.out_b = q.out_b;
						endcase
					end
				end
				KIND_FAST:
				begin
					d.count = at_top ? CNT_BOTTOM : q.count + 1'b1;
					tov_set = at_top; // RULE_17
					upd_now = at_top;
					if (at_top)
					begin
						// Counter wraps to BOTTOM: set or clear action
						if (om_a[1]) d.out_a = ~om_a[0]; // RULE_07
						if (om_b[1]) d.out_b = ~om_b[0]; // RULE_07
					end
					if (match_a && !ignore_a)
					begin
						if (om_a[1]) d.out_a = om_a[0]; // RULE_07
						else if (om_a == OM_TOGGLE && wm inside {WM_FAST_CAPT, WM_FAST_CMP})
							d.out_a = ~q.out_a; // RULE_08
					end
					if (match_b && !ignore_b && om_b[1]) d.out_b = om_b[0]; // RULE_07
				end
				default:
				begin
					// Dual slope: BOTTOM up to TOP then down to BOTTOM
					if (at_top) d.down = 1'b1; // RULE_22
					else if (at_bottom) d.down = 1'b0;
					d.count = (at_top || (q.down && !at_bottom)) ? q.count - 1'b1
					                                             : q.count + 1'b1;
					tov_set = at_bottom; // RULE_15 RULE_16
					upd_now = (kind == KIND_PFC) ? at_bottom : at_top; // RULE_02 RULE_15
					if (match_a)
					begin
						if (om_a[1]) d.out_a = om_a[0] ^ d.down; // RULE_10 RULE_11
						else if (om_a == OM_TOGGLE && wm inside {WM_PFC_CMP, WM_PC_CMP})
							d.out_a = ~q.out_a; // RULE_12
					end
					if (match_b && om_b[1]) d.out_b = om_b[0] ^ d.down; // RULE_10 RULE_11
				end
			endcase
			if (tov_set) d.flags[ST_OVF_BIT] = 1'b1;
			if (match_a) d.flags[ST_CMA_BIT] = 1'b1;
			if (match_b) d.flags[ST_CMB_BIT] = 1'b1;
			if (upd_now)
			begin
				d.cmp_a = q.buf_a;
				d.cmp_b = q.buf_b;
			end
		end

		// Register writes; high bytes go through the shared temp
		d.rdata = 8'h00;
		if (reg_write_i)
		begin
			if (reg_addr_i == ADDR_CTRL_A)
				d.ctrl_a = reg_wdata_i & CTRL_A_WMASK; // RULE_19
			else if (reg_addr_i == ADDR_CTRL_B)
				d.ctrl_b = reg_wdata_i & CTRL_B_WMASK; // RULE_20
			else if (reg_addr_i == ADDR_CMP_A_HI || reg_addr_i == ADDR_CMP_B_HI ||
			         reg_addr_i == ADDR_CAPT_HI || reg_addr_i == ADDR_COUNT_HI)
				d.temp = reg_wdata_i;
			else if (reg_addr_i == ADDR_CMP_A_LO)
				d.buf_a = {q.temp, reg_wdata_i};
			else if (reg_addr_i == ADDR_CMP_B_LO)
				d.buf_b = {q.temp, reg_wdata_i};
			else if (reg_addr_i == ADDR_CAPT_LO)
				d.capt = {q.temp, reg_wdata_i};
			else if (reg_addr_i == ADDR_COUNT_LO)
				d.count = {q.temp, reg_wdata_i};
			else if (reg_addr_i == ADDR_STATUS)
				d.flags = d.flags & ~(reg_wdata_i[2:0] & ~{match_b & tick, match_a & tick,
				                                          tov_set});
		end
		// Non-PWM modes load compare values at once
		if (kind == KIND_NONPWM) // RULE_14
		begin
			d.cmp_a = d.buf_a;
			d.cmp_b = d.buf_b;
		end
		if (reg_read_i)
		begin
			if (reg_addr_i == ADDR_CTRL_A)
				d.rdata = q.ctrl_a;
			else if (reg_addr_i == ADDR_CTRL_B)
				d.rdata = q.ctrl_b;
			else if (reg_addr_i == ADDR_CMP_A_LO)
				d.rdata = q.buf_a[7:0];
			else if (reg_addr_i == ADDR_CMP_A_HI)
				d.rdata = q.buf_a[15:8];
			else if (reg_addr_i == ADDR_CMP_B_LO)
				d.rdata = q.buf_b[7:0];
			else if (reg_addr_i == ADDR_CMP_B_HI)
				d.rdata = q.buf_b[15:8];
			else if (reg_addr_i == ADDR_CAPT_LO)
				d.rdata = q.capt[7:0];
			else if (reg_addr_i == ADDR_CAPT_HI)
				d.rdata = q.capt[15:8];
			else if (reg_addr_i == ADDR_COUNT_LO)
				d.rdata = q.count[7:0];
			else if (reg_addr_i == ADDR_COUNT_HI)
				d.rdata = q.count[15:8];
			else if (reg_addr_i == ADDR_STATUS)
				d.rdata = {5'h00, q.flags};
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic conn_a, conn_b;

	always_comb
	begin
		// Toggle code in PWM kinds connects channel A only in listed modes
		conn_a = (om_a != OM_OFF); // RULE_03 RULE_05
		if (om_a == OM_TOGGLE && kind == KIND_FAST)
			conn_a = wm inside {WM_FAST_CAPT, WM_FAST_CMP}; // RULE_08
		else if (om_a == OM_TOGGLE && kind != KIND_NONPWM)
			conn_a = wm inside {WM_PFC_CMP, WM_PC_CMP}; // RULE_12
		conn_b = (om_b != OM_OFF) && !(om_b == OM_TOGGLE && kind != KIND_NONPWM); // RULE_03
	end

	assign reg_rdata_o      = q.rdata;
	assign compare_out_a_o  = q.out_a;
	assign compare_out_b_o  = q.out_b;
	assign pin_override_a_o = conn_a;
	assign pin_override_b_o = conn_b;
	assign pin_drive_en_a_o = conn_a & dir_out_a_i; // RULE_04
	assign pin_drive_en_b_o = conn_b & dir_out_b_i; // RULE_04

endmodule : timer16_waveform_mode_control

// ===== bench/timer16_assertions.sv
`timescale 1ns/1ps
module timer16_assertions
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_write_i,
	input wire logic       reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	// Pins
	input wire logic       dir_out_a_i,
	input wire logic       dir_out_b_i,
	input wire logic       compare_out_a_o,
	input wire logic       pin_override_a_o,
	input wire logic       pin_override_b_o,
	input wire logic       pin_drive_en_a_o,
	input wire logic       pin_drive_en_b_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire wr_a = reg_write_i && reg_addr_i == ADDR_CTRL_A;

	a_drive_en_a: assert property (pin_drive_en_a_o == (pin_override_a_o & dir_out_a_i))
		else $error("drive enable A wrong");
	a_drive_en_b: assert property (pin_drive_en_b_o == (pin_override_b_o & dir_out_b_i))
		else $error("drive enable B wrong");
	a_ovr_a_off: assert property (wr_a && reg_wdata_i[7:6] == 2'h0 |=> !pin_override_a_o)
		else $error("override A with mode off");
	a_ovr_b_off: assert property (wr_a && reg_wdata_i[5:4] == 2'h0 |=> !pin_override_b_o)
		else $error("override B with mode off");
	a_ovr_a_on: assert property (wr_a && reg_wdata_i[7] |=> pin_override_a_o)
		else $error("no override A");
	a_ovr_b_on: assert property (wr_a && reg_wdata_i[5] |=> pin_override_b_o)
		else $error("no override B");
	a_ctrl_a_rsv: assert property (reg_read_i && reg_addr_i == ADDR_CTRL_A |=> reg_rdata_o[3:2] == 2'h0)
		else $error("control A bits 3:2 not zero");
	a_ctrl_b_rsv: assert property (reg_read_i && reg_addr_i == ADDR_CTRL_B |=> reg_rdata_o[7:5] == 3'h0)
		else $error("control B bits 7:5 not zero");

	c_drive_a: cover property (wr_a ##1 pin_drive_en_a_o);
	c_out_rise: cover property ($rose(compare_out_a_o));
	c_read_b: cover property (reg_read_i && reg_addr_i == ADDR_CTRL_B);
endmodule : timer16_assertions

bind timer16_waveform_mode_control timer16_assertions chk (.ref_clk_i, .rst_i, .reg_addr_i,
	.reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .dir_out_a_i, .dir_out_b_i,
	.compare_out_a_o, .pin_override_a_o, .pin_override_b_o, .pin_drive_en_a_o, .pin_drive_en_b_o);

// ===== bench/timer16_waveform_mode_control_tb_top.sv
`timescale 1ns/1ps
module timer16_waveform_mode_control_tb_top
	import timer16_pkg::*;
;
	logic       ref_clk_i = 0;
	logic       rst_i     = 1;
	logic [7:0] addr      = 0;
	logic [7:0] wdata     = 0;
	logic       we        = 0;
	logic       re        = 0;
	logic       dir_a     = 0;
	logic       dir_b     = 0;
	logic       ext       = 0;
	logic       cap       = 0;
	logic [7:0] rdata;
	logic       oa, ob, va, vb, ea, eb;
	int         fail_count = 0;
	int         comparisons = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	timer16_waveform_mode_control uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(re),
		.reg_rdata_o(rdata), .ext_count_i(ext), .capture_evt_i(cap),
		.dir_out_a_i(dir_a), .dir_out_b_i(dir_b), .compare_out_a_o(oa),
		.compare_out_b_o(ob), .pin_override_a_o(va), .pin_override_b_o(vb),
		.pin_drive_en_a_o(ea), .pin_drive_en_b_o(eb));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task near(string n, int e, int g, int t);
		comparisons++;
		if (g < e - t || g > e + t)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask : near

	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk_i);
		we <= 1; addr <= a; wdata <= d;
		@(posedge ref_clk_i);
		we <= 0;
	endtask : wr

	task rd(logic [7:0] a, logic [7:0] e);
		@(posedge ref_clk_i);
		re <= 1; addr <= a;
		@(posedge ref_clk_i);
		re <= 0;
		#1 chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask : rd

	task w16(logic [7:0] a, logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask : w16

	task cfg(logic [3:0] wm, logic [1:0] ma, logic [1:0] mb, logic [2:0] sel);
		// Stop and park the high mode bits, so no reserved code appears on the way
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_A, {ma, mb, 2'h0, wm[1:0]});
		w16(ADDR_COUNT_LO, 16'h0000);
		wr(ADDR_CTRL_B, {3'h0, wm[3:2], sel});
	endtask : cfg

	task step(int n);
		repeat (n)
		begin
			@(posedge ref_clk_i);
			ext <= 1;
			repeat (4) @(posedge ref_clk_i);
			ext <= 0;
			repeat (4) @(posedge ref_clk_i);
		end
	endtask : step

	task duty(int n, bit ch, output int h);
		h = 0;
		repeat (n)
		begin
			@(negedge ref_clk_i);
			h += ch ? ob : oa;
		end
	endtask : duty

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rd(ADDR_CTRL_A, 8'h00);
		rd(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_A, 8'hff);
		rd(ADDR_CTRL_A, 8'hf3);
		wr(ADDR_CTRL_B, 8'hff);
		rd(ADDR_CTRL_B, 8'h1f);
		rd(8'h00, 8'h00);
		cfg(4'h0, OM_OFF, OM_OFF, SEL_STOP);
		$display("registers done");
	endtask : t_regs

	task t_ovr;
		logic np, tg, xa, xb;
		for (int w = 0; w < 16; w += (w == 12) ? 2 : 1)
			for (int m = 0; m < 4; m++)
			begin
				@(posedge ref_clk_i);
				dir_a <= w[0]; dir_b <= m[0];
				cfg(w[3:0], m[1:0], m[1:0], SEL_STOP);
				np = w == 0 || w == 4 || w == 12 || w == 13;
				tg = w == 9 || w == 11 || w == 14 || w == 15;
				xa = m > 1 || (m == 1 && (np || tg));
				xb = m > 1 || (m == 1 && np);
				@(negedge ref_clk_i);
				chk("override_a", xa, va);
				chk("override_b", xb, vb);
				chk("drive_en_a", xa & dir_a, ea);
				chk("drive_en_b", xb & dir_b, eb);
			end
		$display("override done");
	endtask : t_ovr

	task t_ctc;
		int h;
		w16(ADDR_CMP_A_LO, 16'h0007);
		cfg(4'h4, OM_CLEAR, OM_OFF, SEL_DIV1);
		repeat (20) @(posedge ref_clk_i);
		#1 chk("clear", 0, oa);
		cfg(4'h4, OM_SET, OM_OFF, SEL_DIV1);
		repeat (20) @(posedge ref_clk_i);
		#1 chk("set", 1, oa);
		cfg(4'h4, OM_TOGGLE, OM_OFF, SEL_DIV1);
		duty(32, 0, h);
		near("toggle", 16, h, 1);
		cfg(4'h4, OM_TOGGLE, OM_OFF, SEL_DIV8);
		duty(256, 0, h);
		near("div8", 128, h, 8);
		cfg(4'h4, OM_TOGGLE, OM_OFF, SEL_STOP);
		duty(32, 0, h);
		chk("stopped", 1, h == 0 || h == 32);
		$display("non-pwm done");
	endtask : t_ctc

	task t_flags;
		cfg(WM_NORMAL, OM_OFF, OM_OFF, SEL_EXT_RISE);
		w16(ADDR_CMP_B_LO, 16'h0080);
		w16(ADDR_COUNT_LO, 16'hfffe);
		wr(ADDR_STATUS, 8'h07);
		step(1);
		rd(ADDR_STATUS, 8'h00);
		step(1);
		rd(ADDR_STATUS, 8'h01);
		cfg(WM_FAST_8BIT, OM_OFF, OM_OFF, SEL_EXT_RISE);
		w16(ADDR_COUNT_LO, 16'h00fe);
		wr(ADDR_STATUS, 8'h07);
		step(1);
		rd(ADDR_STATUS, 8'h00);
		step(1);
		rd(ADDR_STATUS, 8'h01);
		cfg(WM_PFC_CMP, OM_OFF, OM_OFF, SEL_EXT_RISE);
		w16(ADDR_CMP_B_LO, 16'h0003);
		wr(ADDR_STATUS, 8'h07);
		step(4);
		rd(ADDR_STATUS, 8'h05);
		cfg(WM_PC_CMP, OM_OFF, OM_OFF, SEL_EXT_RISE);
		w16(ADDR_CMP_B_LO, 16'h0002);
		wr(ADDR_STATUS, 8'h07);
		step(3);
		rd(ADDR_STATUS, 8'h01);
		@(posedge ref_clk_i);
		cap <= 1;
		@(posedge ref_clk_i);
		cap <= 0;
		rd(ADDR_CAPT_LO, 8'h03);
		$display("flags done");
	endtask : t_flags

	task pwm(logic [3:0] wm, logic [1:0] mb, logic [15:0] c, int n, int e, int t);
		int h;
		w16(ADDR_CMP_A_LO, 16'h00ff);
		w16(ADDR_CMP_B_LO, c);
		cfg(wm, OM_OFF, mb, SEL_DIV1);
		repeat (n) @(posedge ref_clk_i);
		duty(n, 1, h);
		near("duty_b", e, h, t);
	endtask : pwm

	task t_pwm;
		pwm(4'h5, OM_CLEAR, 16'h0040, 512, 130, 4);
		pwm(4'h5, OM_SET, 16'h0040, 512, 382, 4);
		pwm(4'h5, OM_CLEAR, 16'h00ff, 512, 512, 1);
		pwm(4'hf, OM_CLEAR, 16'h0040, 512, 130, 4);
		pwm(4'h1, OM_CLEAR, 16'h0040, 1020, 256, 8);
		pwm(4'h1, OM_SET, 16'h0040, 1020, 764, 8);
		pwm(4'h9, OM_CLEAR, 16'h0040, 1020, 256, 8);
		$display("pwm done");
	endtask : t_pwm

	task wrap_up;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		#500000;
		fail_count++;
		wrap_up();
	end

	initial
	begin
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 0;
		t_regs();
		t_ovr();
		t_ctc();
		t_flags();
		t_pwm();
		wrap_up();
	end
endmodule : timer16_waveform_mode_control_tb_top
